// *** src/pmu_regs_defines.svh ***
`ifndef PMU_REGS_DEFINES_SVH
`define PMU_REGS_DEFINES_SVH

`define ADDR_BATT_MON 8'h00
`define ADDR_THERMAL 8'h01
`define ADDR_B1_VOLT 8'h10
`define ADDR_B1_CTRL 8'h12
`define ADDR_B2_PRI 8'h20
`define ADDR_B2_SEC 8'h21
`define ADDR_B2_CTRL 8'h22
`define ADDR_B3_PRI 8'h30
`define ADDR_B3_SEC 8'h31
`define ADDR_B3_CTRL 8'h32

`define BIT_IRQ_UNMASK 7
`define BIT_IRQ_FLAG 6
`define BIT_BATT_LIVE 5
`define BIT_BATT_RSVD 4
`define BIT_REG_ON 7
`define BIT_REG_PHASE 2
`define BIT_FAULT_UNMASK 1
`define BIT_POWER_GOOD 0

`define RST_VCODE 6'h00
`define RST_THRESH 4'h0

`endif

// *** src/pmu_regs_pkg.sv ***
package pmu_regs_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic on;
    logic phase;
    logic fault_irq_unmask;
    logic [5:0] vcode;
  } buck_out_t;
endpackage

// *** src/buck_ctrl.sv ***
`timescale 1ns/1ps
`include "pmu_regs_defines.svh"

// Control register and voltage codes for one step-down regulator.
module buck_ctrl
  import pmu_regs_pkg::*;
#(
  parameter logic [7:0] ctrl_addr = 8'h12,
  parameter logic [7:0] pri_addr = 8'h10,
  parameter logic [7:0] sec_addr = 8'h11,
  parameter bit has_sec = 1'b0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input pmu_regs_pkg::bus_req_t req,
  input wire logic sel_hi,
  output pmu_regs_pkg::buck_out_t out,
  output logic [5:0] pri_code,
  output logic [5:0] sec_code
);
  logic reg_on;
  logic reg_phase;
  logic reg_fault_unmask;
  logic [5:0] applied_code;

  // Each field has its own flop so that every bit of the output has one driver.
  assign out = '{on: reg_on, phase: reg_phase,
                 fault_irq_unmask: reg_fault_unmask, vcode: applied_code};

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_on <= 1'b0;
      reg_phase <= 1'b0;
      reg_fault_unmask <= 1'b0;
    end else if (clk_en && req.wr && req.addr == ctrl_addr) begin
      reg_on <= req.wdata[`BIT_REG_ON];
      reg_phase <= req.wdata[`BIT_REG_PHASE];
      reg_fault_unmask <= req.wdata[`BIT_FAULT_UNMASK];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pri_code <= `RST_VCODE;
      sec_code <= `RST_VCODE;
    end else if (clk_en && req.wr) begin
      if (req.addr == pri_addr) begin
        pri_code <= req.wdata[5:0];
      end
      if (has_sec && req.addr == sec_addr) begin
        sec_code <= req.wdata[5:0];
      end
    end
  end

  // Applied code follows the select level; second and third regulators only.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      applied_code <= `RST_VCODE;
    end else if (clk_en) begin
      applied_code <= (has_sec && sel_hi) ? sec_code : pri_code;
    end
  end
endmodule

// *** src/pmu_regs.sv ***
`timescale 1ns/1ps
`include "pmu_regs_defines.svh"

module pmu_regs
  import pmu_regs_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic voltage_select_pin,
  input wire logic battery_below_pin,
  input wire logic thermal_event_pin,
  input wire logic [2:0] power_good_pin,
  input wire logic [2:0] fault_pin,
  output logic [3:0] battery_threshold_code,
  output pmu_regs_pkg::buck_out_t buck1,
  output pmu_regs_pkg::buck_out_t buck2,
  output pmu_regs_pkg::buck_out_t buck3,
  output logic irq
);
  import pmu_regs_pkg::*;

  bus_req_t req;
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic sel_hi;
  logic batt_live;
  logic therm_live;
  logic therm_prev;
  logic batt_prev;
  logic [2:0] pgood;
  logic [2:0] fault;
  logic battery_level_irq_unmask;
  logic battery_level_irq_flag;
  logic thermal_irq_unmask;
  logic thermal_irq_flag;
  logic battery_rsvd;
  logic [5:0] thermal_rsvd;
  logic [5:0] b1_pri;
  logic [5:0] b2_pri;
  logic [5:0] b2_sec;
  logic [5:0] b3_pri;
  logic [5:0] b3_sec;
  logic batt_event;
  logic therm_event;
  logic next_irq;
  logic [7:0] next_rdata;

  assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};

  // Two-stage synchronisers for all pin inputs.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else if (clk_en) begin
      sync1 <= {fault_pin, power_good_pin, thermal_event_pin,
                battery_below_pin};
      sync2 <= sync1;
    end
  end

  assign batt_live = sync2[0];
  assign therm_live = sync2[1];
  assign pgood = sync2[4:2];
  assign fault = sync2[7:5];

  logic sel_s1;
  logic voltage_select_pin_s;
  assign sel_hi = voltage_select_pin_s;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sel_s1 <= 1'b0;
      voltage_select_pin_s <= 1'b0;
    end else if (clk_en) begin
      sel_s1 <= voltage_select_pin;
      voltage_select_pin_s <= sel_s1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      batt_prev <= 1'b0;
      therm_prev <= 1'b0;
    end else if (clk_en) begin
      batt_prev <= batt_live;
      therm_prev <= therm_live;
    end
  end

  // A battery event is the comparator crossing below the threshold.
  assign batt_event = batt_live && !batt_prev;
  assign therm_event = therm_live && !therm_prev;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      battery_level_irq_unmask <= 1'b0;
      battery_rsvd <= 1'b0;
      battery_threshold_code <= `RST_THRESH;
    end else if (clk_en && req.wr && req.addr == `ADDR_BATT_MON) begin
      battery_level_irq_unmask <= req.wdata[`BIT_IRQ_UNMASK];
      battery_rsvd <= req.wdata[`BIT_BATT_RSVD];
      battery_threshold_code <= req.wdata[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      thermal_irq_unmask <= 1'b0;
      thermal_rsvd <= 6'h00;
    end else if (clk_en && req.wr && req.addr == `ADDR_THERMAL) begin
      thermal_irq_unmask <= req.wdata[`BIT_IRQ_UNMASK];
      thermal_rsvd <= req.wdata[5:0];
    end
  end

  // Flags are sticky and cleared by reading their register; a new event in
  // the same cycle as the clearing read wins.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      battery_level_irq_flag <= 1'b0;
    end else if (clk_en) begin
      if (batt_event) begin
        battery_level_irq_flag <= 1'b1;
      end else if (req.rd && req.addr == `ADDR_BATT_MON) begin
        battery_level_irq_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      thermal_irq_flag <= 1'b0;
    end else if (clk_en) begin
      if (therm_event) begin
        thermal_irq_flag <= 1'b1;
      end else if (req.rd && req.addr == `ADDR_THERMAL) begin
        thermal_irq_flag <= 1'b0;
      end
    end
  end

  buck_ctrl #(
    .ctrl_addr(`ADDR_B1_CTRL),
    .pri_addr(`ADDR_B1_VOLT),
    .sec_addr(`ADDR_B1_VOLT),
    .has_sec(1'b0)
  ) u_buck1 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .req(req),
    .sel_hi(sel_hi),
    .out(buck1),
    .pri_code(b1_pri),
    .sec_code()
  );

  buck_ctrl #(
    .ctrl_addr(`ADDR_B2_CTRL),
    .pri_addr(`ADDR_B2_PRI),
    .sec_addr(`ADDR_B2_SEC),
    .has_sec(1'b1)
  ) u_buck2 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .req(req),
    .sel_hi(sel_hi),
    .out(buck2),
    .pri_code(b2_pri),
    .sec_code(b2_sec)
  );

  buck_ctrl #(
    .ctrl_addr(`ADDR_B3_CTRL),
    .pri_addr(`ADDR_B3_PRI),
    .sec_addr(`ADDR_B3_SEC),
    .has_sec(1'b1)
  ) u_buck3 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .req(req),
    .sel_hi(sel_hi),
    .out(buck3),
    .pri_code(b3_pri),
    .sec_code(b3_sec)
  );

  function automatic logic [7:0] ctrl_word(input buck_out_t b,
                                           input logic pg);
    ctrl_word = {b.on, 4'h0, b.phase, b.fault_irq_unmask, pg};
  endfunction

  // Read-only fields come from live state or the sticky flags, so writes cannot reach them.
  always_comb begin
    next_rdata = 8'h00;
    case (req.addr)
      `ADDR_BATT_MON: next_rdata = {battery_level_irq_unmask,
        battery_level_irq_flag, batt_live, battery_rsvd,
        battery_threshold_code};
      `ADDR_THERMAL: next_rdata = {thermal_irq_unmask, thermal_irq_flag,
        thermal_rsvd};
      `ADDR_B1_VOLT: next_rdata = {2'h0, b1_pri};
      `ADDR_B1_CTRL: next_rdata = ctrl_word(buck1, pgood[0]);
      `ADDR_B2_PRI: next_rdata = {2'h0, b2_pri};
      `ADDR_B2_SEC: next_rdata = {2'h0, b2_sec};
      `ADDR_B2_CTRL: next_rdata = ctrl_word(buck2, pgood[1]);
      `ADDR_B3_PRI: next_rdata = {2'h0, b3_pri};
      `ADDR_B3_SEC: next_rdata = {2'h0, b3_sec};
      `ADDR_B3_CTRL: next_rdata = ctrl_word(buck3, pgood[2]);
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (clk_en) begin
      rdata <= req.rd ? next_rdata : 8'h00;
    end
  end

  // Faults are level sources gated by each regulator's fault-unmask bit.
  assign next_irq = (battery_level_irq_flag && battery_level_irq_unmask) ||
    (thermal_irq_flag && thermal_irq_unmask) ||
    (fault[0] && buck1.fault_irq_unmask) ||
    (fault[1] && buck2.fault_irq_unmask) ||
    (fault[2] && buck3.fault_irq_unmask);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= next_irq;
    end
  end

  a_irq_follows_flag: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    clk_en && battery_level_irq_flag && battery_level_irq_unmask |=> irq)
    else $error("irq missing for unmasked battery flag");

  a_batt_flag_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && batt_event |=> battery_level_irq_flag)
    else $error("battery flag not set");

  a_live_bit_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && req.rd && req.addr == `ADDR_BATT_MON |=>
    rdata[`BIT_BATT_LIVE] == $past(batt_live))
    else $error("live battery bit wrong");

  a_thresh_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && req.wr && req.addr == `ADDR_BATT_MON |=>
    battery_threshold_code == $past(req.wdata[3:0]))
    else $error("threshold not stored");

  a_therm_masked: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && !thermal_irq_unmask && !battery_level_irq_flag && fault == 3'h0
    |=> !irq)
    else $error("masked thermal raised irq");

  a_therm_flag_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && therm_event |=> thermal_irq_flag)
    else $error("thermal flag not set");

  a_b1_code_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && req.wr && req.addr == `ADDR_B1_VOLT |=>
    b1_pri == $past(req.wdata[5:0]) ##1
    (buck1.vcode == $past(b1_pri) || !clk_en))
    else $error("regulator one code wrong");

  a_voltage_select_pin_code: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && $past(clk_en) |->
    buck2.vcode == ($past(sel_hi) ? $past(b2_sec) : $past(b2_pri)))
    else $error("regulator two code not selected");

  a_ctrl_on_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && req.wr && req.addr == `ADDR_B2_CTRL |=>
    buck2.on == $past(req.wdata[7]) && buck2.phase == $past(req.wdata[2]))
    else $error("control bits not stored");

  a_pgood_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && req.rd && req.addr == `ADDR_B1_CTRL |=>
    rdata[0] == $past(pgood[0]) && rdata[6:3] == 4'h0)
    else $error("power-good read wrong");
endmodule

// *** verif/tb_pmu_regs.sv ***
`timescale 1ns/1ps

module tb_pmu_regs;
  import pmu_regs_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic voltage_select_pin = 1'b0;
  logic battery_below_pin = 1'b0;
  logic thermal_event_pin = 1'b0;
  logic [2:0] power_good_pin = 3'h0;
  logic [2:0] fault_pin = 3'h0;
  logic [3:0] battery_threshold_code;
  buck_out_t buck1;
  buck_out_t buck2;
  buck_out_t buck3;
  logic irq;
  int mismatches = 0;
  int checks_done = 0;
  logic [7:0] d;

  pmu_regs pmu_regs_i (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rdata(rdata),
    .voltage_select_pin(voltage_select_pin),
    .battery_below_pin(battery_below_pin),
    .thermal_event_pin(thermal_event_pin),
    .power_good_pin(power_good_pin),
    .fault_pin(fault_pin),
    .battery_threshold_code(battery_threshold_code),
    .buck1(buck1),
    .buck2(buck2),
    .buck3(buck3),
    .irq(irq)
  );

  always #50 core_clk = ~core_clk;

  task automatic end_of_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask

  // The read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic test_reset_values();
    logic [7:0] regs [5] = '{8'h00, 8'h01, 8'h10, 8'h12, 8'h20};
    foreach (regs[i]) begin
      rd(regs[i], d);
      chk("reset value", d, 8'h00);
    end
    chk("irq after reset", {7'h00, irq}, 8'h00);
  endtask

  task automatic test_battery();
    wr(8'h00, 8'hFF);
    cyc(1);
    chk("threshold out", {4'h0, battery_threshold_code}, 8'h0F);
    rd(8'h00, d);
    chk("batt reg ro bits", d, 8'h9F);
    battery_below_pin <= 1'b1;
    cyc(6);
    chk("batt irq", {7'h00, irq}, 8'h01);
    rd(8'h00, d);
    chk("batt flag live", d, 8'hFF);
    cyc(4);
    chk("batt irq cleared", {7'h00, irq}, 8'h00);
    rd(8'h00, d);
    chk("batt flag clear", d, 8'hBF);
    wr(8'h00, 8'h1F);
    battery_below_pin <= 1'b0;
    cyc(6);
    battery_below_pin <= 1'b1;
    cyc(6);
    chk("batt masked irq", {7'h00, irq}, 8'h00);
    rd(8'h00, d);
    chk("batt masked flag", d, 8'h7F);
    battery_below_pin <= 1'b0;
    cyc(6);
    rd(8'h00, d);
    chk("batt live low", d, 8'h1F);
  endtask

  task automatic test_thermal();
    wr(8'h01, 8'hFF);
    rd(8'h01, d);
    chk("therm reg ro bit", d, 8'hBF);
    thermal_event_pin <= 1'b1;
    cyc(6);
    chk("therm irq", {7'h00, irq}, 8'h01);
    rd(8'h01, d);
    chk("therm flag", d, 8'hFF);
    cyc(4);
    chk("therm irq cleared", {7'h00, irq}, 8'h00);
    thermal_event_pin <= 1'b0;
    wr(8'h01, 8'h00);
    cyc(6);
    thermal_event_pin <= 1'b1;
    cyc(6);
    chk("therm masked irq", {7'h00, irq}, 8'h00);
    rd(8'h01, d);
    chk("therm masked flag", d, 8'h40);
    thermal_event_pin <= 1'b0;
  endtask

  task automatic test_buck1();
    wr(8'h10, 8'hFF);
    cyc(1);
    chk("buck1 vcode", {2'b00, buck1.vcode}, 8'h3F);
    rd(8'h10, d);
    chk("buck1 vcode reg", d, 8'h3F);
    power_good_pin <= 3'b001;
    wr(8'h12, 8'hFF);
    cyc(5);
    rd(8'h12, d);
    chk("buck1 ctrl reg", d, 8'h87);
    chk("buck1 ctrl out", {5'h00, buck1.on, buck1.phase,
        buck1.fault_irq_unmask}, 8'h07);
    fault_pin <= 3'b001;
    cyc(6);
    chk("fault irq", {7'h00, irq}, 8'h01);
    wr(8'h12, 8'h84);
    cyc(3);
    chk("fault masked", {7'h00, irq}, 8'h00);
    power_good_pin <= 3'b000;
    cyc(5);
    rd(8'h12, d);
    chk("buck1 pgood low", d, 8'h84);
    wr(8'h12, 8'h00);
    cyc(1);
    chk("buck1 off", {5'h00, buck1.on, buck1.phase,
        buck1.fault_irq_unmask}, 8'h00);
    fault_pin <= 3'b000;
  endtask

  task automatic test_select();
    wr(8'h20, 8'h15);
    wr(8'h21, 8'h2A);
    wr(8'h30, 8'h33);
    wr(8'h31, 8'h0C);
    wr(8'h32, 8'h84);
    power_good_pin <= 3'b010;
    wr(8'h22, 8'h86);
    cyc(5);
    chk("buck2 primary", {2'b00, buck2.vcode}, 8'h15);
    chk("buck3 primary", {2'b00, buck3.vcode}, 8'h33);
    chk("buck3 ctrl out", {5'h00, buck3.on, buck3.phase,
        buck3.fault_irq_unmask}, 8'h06);
    rd(8'h21, d);
    chk("buck2 sec reg", d, 8'h2A);
    rd(8'h22, d);
    chk("buck2 ctrl reg", d, 8'h87);
    voltage_select_pin <= 1'b1;
    cyc(6);
    chk("buck2 secondary", {2'b00, buck2.vcode}, 8'h2A);
    chk("buck3 secondary", {2'b00, buck3.vcode}, 8'h0C);
    voltage_select_pin <= 1'b0;
    cyc(6);
    chk("buck2 back", {2'b00, buck2.vcode}, 8'h15);
    chk("buck3 back", {2'b00, buck3.vcode}, 8'h33);
  endtask

  task automatic test_unmapped();
    wr(8'h7F, 8'hA5);
    rd(8'h7F, d);
    chk("unmapped", d, 8'h00);
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    test_reset_values();
    test_battery();
    test_thermal();
    test_buck1();
    test_select();
    test_unmapped();
    end_of_test();
  end

  initial begin
    #2000000;
    mismatches++;
    end_of_test();
  end
endmodule
